// >>> rtl/efh_cfg.svh
// efh_cfg.svh - offsets, field positions, reset values and counts of the
// ethernet frame handler. assumes byte-addressed 32-bit register port.
`ifndef EFH_CFG_SVH
`define EFH_CFG_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define EFH_OFF_MAC_CONFIG_ONE   8'h00
`define EFH_OFF_MAC_CONFIG_THREE 8'h04
`define EFH_OFF_RX_FILTER_CONFIG 8'h08
`define EFH_OFF_RX_REGION_START  8'h0c
`define EFH_OFF_RX_REGION_END    8'h10
`define EFH_OFF_RX_WRITE_POINTER 8'h14
`define EFH_OFF_RX_READ_PTR_LOW  8'h18
`define EFH_OFF_RX_READ_PTR_HIGH 8'h1c
`define EFH_OFF_BUF_POINTER      8'h20
`define EFH_OFF_BUF_DATA         8'h24
`define EFH_OFF_TX_START         8'h28
`define EFH_OFF_TX_END           8'h2c
`define EFH_OFF_COMMAND          8'h30
`define EFH_OFF_ETHERNET_STATUS  8'h34
`define EFH_OFF_STATION_LOW      8'h38
`define EFH_OFF_STATION_HIGH     8'h3c
`define EFH_OFF_RX_LAST_LENGTH   8'h40

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define EFH_MC1_RXEN      0
`define EFH_MC3_HUGE      0
`define EFH_MC3_PAD_LSB   1
`define EFH_FLT_UNICAST   0
`define EFH_FLT_MULTICAST 1
`define EFH_FLT_BROADCAST 2
`define EFH_FLT_CRC_FILTER_ENABLE     7
`define EFH_CMD_TX_START  0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define EFH_RST_MC1       8'h00
`define EFH_RST_MC3       4'h0
`define EFH_RST_FILTER    8'h85
`define EFH_RST_RX_START  13'h0000
`define EFH_RST_RX_END    13'h1fff

// ----------------------------------------------------------------------
// frame constants and counts
// ----------------------------------------------------------------------
`define EFH_PREAMBLE_BYTE 8'h55
`define EFH_SFD_BYTE      8'hd5
`define EFH_PREAMBLE_LEN  4'h7
`define EFH_CRC_LEN       4'h4
`define EFH_TSV_LEN       4'h7
`define EFH_MIN_PAD_LEN   16'h003c
`define EFH_MIN_RX_LEN    16'h0012
`define EFH_MAX_STD_LEN   16'h05ee
`define EFH_CRC_INIT      32'hffffffff
`define EFH_CRC_POLY      32'hedb88320
`define EFH_CRC_RESIDUE   32'hdebb20e3

`endif

// >>> rtl/efh_pkg.sv
// efh_pkg.sv - state types of the ethernet frame handler.
// assumes efh_cfg.svh supplies the numeric constants.
package efh_pkg;

  typedef enum logic [2:0] {
    EFH_TX_IDLE,
    EFH_TX_PRE,
    EFH_TX_DATA,
    EFH_TX_PAD,
    EFH_TX_CRC,
    EFH_TX_STAT
  } efh_tx_state_t;

  typedef enum logic [1:0] {
    EFH_RX_IDLE,
    EFH_RX_PRE,
    EFH_RX_DATA,
    EFH_RX_SKIP
  } efh_rx_state_t;

endpackage : efh_pkg

// >>> rtl/efh_frame_handler.sv
// efh_frame_handler.sv - frame handling of an ethernet controller with an
// 8-kbyte shared packet buffer, register port and byte-wide link.
// assumes one clock, link bytes synchronous to clk_sys, one byte a cycle.
//
// Notes on behaviour
// R1 - add preamble/delimiter on send, strip on receive
// R2 - received padding and crc stored in buffer
// R3 - destination lowest bit one means multicast
// R4 - all-ones destination is broadcast
// R5 - filter frames by multicast, broadcast, unicast class
// R6 - host writes both addresses into transmit buffer
// R7 - host handles type/length meaning
// R8 - payload limited unless huge frame enable set
// R9 - zero pad to 60 when pad field says
// R10 - short frames sent when padding not selected
// R11 - drop received frames below 18 bytes
// R12 - host discards frames shorter than 64
// R13 - check crc; filter enable discards bad frames
// R14 - append crc when pad field requests it
// R15 - start through end inclusive is receive region
// R16 - pointer write reloads internal write position
// R17 - visible write pointer moves on good frame
// R18 - host sets read pointer low then high
// R19 - seven-byte transmit status after last byte
// R20 - memory outside receive region is transmit space
// R21 - host waits clock ready before configuring
// R22 - receive only while mac receive enable set
// R23 - one shared 8-kbyte packet buffer
// R24 - standard crc-32, init ones, result inverted
`timescale 1ns/1ns
`include "efh_cfg.svh"

module efh_frame_handler (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        clock_ready_in,
  output logic      [7:0]  tx_byte,
  output logic             tx_en,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_dv
);

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `EFH_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  // next position inside the receive region, wrapping end back to start
  function automatic logic [12:0] ring_next(input logic [12:0] p, input logic [12:0] s,
                                            input logic [12:0] e);
    return (p == e) ? s : p + 13'h0001;
  endfunction : ring_next

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off, input logic s);
    return s && (a == off);
  endfunction : hit

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [7:0]          mem [8192]; // R23
  logic [7:0]          mc1_q;
  logic [3:0]          mc3_q;
  logic [7:0]          filt_q;
  logic [12:0]         rx_start_q;
  logic [12:0]         rx_end_q;
  logic [12:0]         rx_wrptr_vis_q;
  logic [7:0]          rdptr_low_q;
  logic [12:0]         rdptr_q;
  logic [12:0]         bufptr_q;
  logic [12:0]         tx_start_q;
  logic [12:0]         tx_end_q;
  logic [47:0]         station_q;
  logic [15:0]         rx_last_len_q;
  logic [3:0]          rx_last_stat_q;
  logic [31:0]         rdata_q;
  efh_pkg::efh_tx_state_t tx_state_q;
  logic [15:0]         tx_cnt_q;
  logic [12:0]         tx_idx_q;
  logic [3:0]          tx_sub_q;
  logic [31:0]         tx_crc_q;
  logic                tx_long_q;
  logic [7:0]          tx_byte_q;
  logic                tx_en_q;
  efh_pkg::efh_rx_state_t rx_state_q;
  logic [12:0]         rx_pos_q;
  logic [12:0]         rx_frame_q;
  logic [15:0]         rx_cnt_q;
  logic [31:0]         rx_crc_q;
  logic [47:0]         dest_q;
  logic                rx_ovf_q;

  // ----------------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------------
  wire wr_mc1    = hit(reg_addr, `EFH_OFF_MAC_CONFIG_ONE, reg_wr);
  wire wr_mc3    = hit(reg_addr, `EFH_OFF_MAC_CONFIG_THREE, reg_wr);
  wire wr_filt   = hit(reg_addr, `EFH_OFF_RX_FILTER_CONFIG, reg_wr);
  wire wr_rxst   = hit(reg_addr, `EFH_OFF_RX_REGION_START, reg_wr);
  wire wr_rxnd   = hit(reg_addr, `EFH_OFF_RX_REGION_END, reg_wr);
  wire wr_rdlo   = hit(reg_addr, `EFH_OFF_RX_READ_PTR_LOW, reg_wr);
  wire wr_rdhi   = hit(reg_addr, `EFH_OFF_RX_READ_PTR_HIGH, reg_wr);
  wire wr_bufptr = hit(reg_addr, `EFH_OFF_BUF_POINTER, reg_wr);
  wire wr_bufdat = hit(reg_addr, `EFH_OFF_BUF_DATA, reg_wr);
  wire rd_bufdat = hit(reg_addr, `EFH_OFF_BUF_DATA, reg_rd);
  wire wr_txst   = hit(reg_addr, `EFH_OFF_TX_START, reg_wr);
  wire wr_txnd   = hit(reg_addr, `EFH_OFF_TX_END, reg_wr);
  wire wr_cmd    = hit(reg_addr, `EFH_OFF_COMMAND, reg_wr);
  wire wr_stlo   = hit(reg_addr, `EFH_OFF_STATION_LOW, reg_wr);
  wire wr_sthi   = hit(reg_addr, `EFH_OFF_STATION_HIGH, reg_wr);
  wire [12:0] wd13 = reg_wdata[12:0];
  wire        rx_ptr_wr = wr_rxst || wr_rxnd;
  wire [12:0] new_start = wr_rxst ? wd13 : rx_start_q;

  wire        tx_busy = (tx_state_q != efh_pkg::EFH_TX_IDLE);
  wire        rx_busy = (rx_state_q == efh_pkg::EFH_RX_DATA);
  wire [7:0]  status = {2'b00, rx_last_stat_q, tx_busy, clock_ready_in};

  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `EFH_OFF_MAC_CONFIG_ONE:   rd_mux = {24'h000000, mc1_q};
      `EFH_OFF_MAC_CONFIG_THREE: rd_mux = {28'h0000000, mc3_q};
      `EFH_OFF_RX_FILTER_CONFIG: rd_mux = {24'h000000, filt_q};
      `EFH_OFF_RX_REGION_START:  rd_mux = {19'h0, rx_start_q};
      `EFH_OFF_RX_REGION_END:    rd_mux = {19'h0, rx_end_q};
      `EFH_OFF_RX_WRITE_POINTER: rd_mux = {19'h0, rx_wrptr_vis_q};
      `EFH_OFF_RX_READ_PTR_LOW:  rd_mux = {24'h000000, rdptr_q[7:0]};
      `EFH_OFF_RX_READ_PTR_HIGH: rd_mux = {27'h0, rdptr_q[12:8]};
      `EFH_OFF_BUF_POINTER:      rd_mux = {19'h0, bufptr_q};
      `EFH_OFF_BUF_DATA:         rd_mux = {24'h000000, mem[bufptr_q]};
      `EFH_OFF_TX_START:         rd_mux = {19'h0, tx_start_q};
      `EFH_OFF_TX_END:           rd_mux = {19'h0, tx_end_q};
      `EFH_OFF_ETHERNET_STATUS:  rd_mux = {22'h0, rx_busy, 1'b0, status};
      `EFH_OFF_STATION_LOW:      rd_mux = station_q[31:0];
      `EFH_OFF_STATION_HIGH:     rd_mux = {16'h0000, station_q[47:32]};
      `EFH_OFF_RX_LAST_LENGTH:   rd_mux = {16'h0000, rx_last_len_q};
      default:                   rd_mux = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mc1_q       <= `EFH_RST_MC1;
      mc3_q       <= `EFH_RST_MC3;
      filt_q      <= `EFH_RST_FILTER;
      rx_start_q  <= `EFH_RST_RX_START;
      rx_end_q    <= `EFH_RST_RX_END;
      rdptr_low_q <= 8'h00;
      rdptr_q     <= `EFH_RST_RX_START;
      bufptr_q    <= 13'h0000;
      tx_start_q  <= 13'h0000;
      tx_end_q    <= 13'h0000;
      station_q   <= 48'h000000000000;
      rdata_q     <= 32'h00000000;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 32'h00000000;
      if (wr_mc1) mc1_q <= reg_wdata[7:0];
      if (wr_mc3) mc3_q <= reg_wdata[3:0];
      if (wr_filt) filt_q <= reg_wdata[7:0];
      if (wr_rxst) rx_start_q <= wd13; // R15
      if (wr_rxnd) rx_end_q <= wd13; // R15
      if (wr_rdlo) rdptr_low_q <= reg_wdata[7:0];
      if (wr_rdhi) rdptr_q <= {reg_wdata[4:0], rdptr_low_q}; // R18
      if (wr_bufptr) bufptr_q <= wd13;
      else if (wr_bufdat || rd_bufdat) bufptr_q <= bufptr_q + 13'h0001;
      if (wr_txst) tx_start_q <= wd13; // R20
      if (wr_txnd) tx_end_q <= wd13;
      if (wr_stlo) station_q[31:0] <= reg_wdata;
      if (wr_sthi) station_q[47:32] <= reg_wdata[15:0];
    end
  end

  // ----------------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------------
  wire [2:0]  pad_cfg  = mc3_q[`EFH_MC3_PAD_LSB +: 3];
  wire        pad_on   = pad_cfg[0]; // R9
  wire        crc_on   = (pad_cfg != 3'b000); // R14
  wire        huge_on  = mc3_q[`EFH_MC3_HUGE];
  wire [7:0]  tx_cur   = mem[tx_idx_q];
  wire [15:0] tx_cnt1  = tx_cnt_q + 16'h0001;
  wire        tx_short = pad_on && (tx_cnt1 < `EFH_MIN_PAD_LEN); // R9 R10
  wire        tx_limit = !huge_on && (tx_cnt1 >= (`EFH_MAX_STD_LEN - 16'h0004)); // R8
  wire        tx_last  = (tx_idx_q == tx_end_q) || tx_limit;
  wire [12:0] tsv_addr = tx_end_q + 13'h0001 + {9'h000, tx_sub_q};
  wire        rx_wr;
  logic [7:0] tsv_byte;
  always_comb begin
    case (tx_sub_q)
      4'h0:    tsv_byte = tx_cnt_q[7:0];
      4'h1:    tsv_byte = tx_cnt_q[15:8];
      4'h2:    tsv_byte = {5'h00, tx_long_q, pad_on, crc_on};
      default: tsv_byte = 8'h00;
    endcase
  end
  wire tsv_wr = (tx_state_q == efh_pkg::EFH_TX_STAT) && !rx_wr; // R19

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_q <= efh_pkg::EFH_TX_IDLE;
      tx_cnt_q   <= 16'h0000;
      tx_idx_q   <= 13'h0000;
      tx_sub_q   <= 4'h0;
      tx_crc_q   <= `EFH_CRC_INIT;
      tx_long_q  <= 1'b0;
      tx_byte_q  <= 8'h00;
      tx_en_q    <= 1'b0;
    end else begin
      case (tx_state_q)
        efh_pkg::EFH_TX_IDLE: begin
          tx_en_q <= 1'b0;
          if (wr_cmd && reg_wdata[`EFH_CMD_TX_START]) begin
            tx_state_q <= efh_pkg::EFH_TX_PRE;
            tx_cnt_q   <= 16'h0000;
            tx_idx_q   <= tx_start_q;
            tx_sub_q   <= 4'h0;
            tx_crc_q   <= `EFH_CRC_INIT; // R24
          end
        end
        efh_pkg::EFH_TX_PRE: begin
          tx_en_q   <= 1'b1;
          tx_byte_q <= (tx_sub_q == `EFH_PREAMBLE_LEN) ? `EFH_SFD_BYTE : `EFH_PREAMBLE_BYTE; // R1
          tx_sub_q  <= tx_sub_q + 4'h1;
          if (tx_sub_q == `EFH_PREAMBLE_LEN) tx_state_q <= efh_pkg::EFH_TX_DATA;
        end
        efh_pkg::EFH_TX_DATA: begin
          tx_byte_q <= tx_cur;
          tx_crc_q  <= crc_byte(tx_crc_q, tx_cur); // R24
          tx_cnt_q  <= tx_cnt1;
          tx_idx_q  <= tx_idx_q + 13'h0001;
          tx_sub_q  <= 4'h0;
          if (tx_last) begin
            tx_long_q  <= tx_limit && (tx_idx_q != tx_end_q);
            tx_state_q <= tx_short ? efh_pkg::EFH_TX_PAD :
                          crc_on   ? efh_pkg::EFH_TX_CRC : efh_pkg::EFH_TX_STAT;
          end
        end
        efh_pkg::EFH_TX_PAD: begin
          tx_byte_q <= 8'h00; // R9
          tx_crc_q  <= crc_byte(tx_crc_q, 8'h00);
          tx_cnt_q  <= tx_cnt1;
          if (!tx_short) tx_state_q <= efh_pkg::EFH_TX_CRC;
        end
        efh_pkg::EFH_TX_CRC: begin
          tx_byte_q <= ~tx_crc_q[7:0]; // R14 R24
          tx_crc_q  <= {8'hff, tx_crc_q[31:8]};
          tx_cnt_q  <= tx_cnt1;
          tx_sub_q  <= tx_sub_q + 4'h1;
          if (tx_sub_q == (`EFH_CRC_LEN - 4'h1)) begin
            tx_sub_q   <= 4'h0;
            tx_state_q <= efh_pkg::EFH_TX_STAT;
          end
        end
        efh_pkg::EFH_TX_STAT: begin
          tx_en_q <= 1'b0;
          if (tsv_wr) begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == (`EFH_TSV_LEN - 4'h1)) tx_state_q <= efh_pkg::EFH_TX_IDLE;
          end
        end
        default: tx_state_q <= efh_pkg::EFH_TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------------
  wire [12:0] rx_nxt   = ring_next(rx_pos_q, rx_start_q, rx_end_q); // R15
  assign      rx_wr    = rx_busy && rx_dv && !rx_ovf_q; // R2
  wire        is_mc    = dest_q[40]; // R3
  wire        is_bc    = &dest_q; // R4
  wire        uc_hit   = !is_mc && (dest_q == station_q);
  wire        filt_ok  = (is_bc && filt_q[`EFH_FLT_BROADCAST]) ||
                         (is_mc && !is_bc && filt_q[`EFH_FLT_MULTICAST]) ||
                         (uc_hit && filt_q[`EFH_FLT_UNICAST]); // R5
  wire        crc_ok   = (rx_crc_q == `EFH_CRC_RESIDUE); // R13
  wire        len_ok   = (rx_cnt_q >= `EFH_MIN_RX_LEN) &&
                         (huge_on || rx_cnt_q <= `EFH_MAX_STD_LEN); // R8 R11
  wire        accept   = len_ok && filt_ok && !rx_ovf_q &&
                         !(filt_q[`EFH_FLT_CRC_FILTER_ENABLE] && !crc_ok); // R13

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_q     <= efh_pkg::EFH_RX_IDLE;
      rx_pos_q       <= `EFH_RST_RX_START;
      rx_frame_q     <= `EFH_RST_RX_START;
      rx_wrptr_vis_q <= `EFH_RST_RX_START;
      rx_cnt_q       <= 16'h0000;
      rx_crc_q       <= `EFH_CRC_INIT;
      dest_q         <= 48'h000000000000;
      rx_ovf_q       <= 1'b0;
      rx_last_len_q  <= 16'h0000;
      rx_last_stat_q <= 4'h0;
    end else begin
      case (rx_state_q)
        efh_pkg::EFH_RX_IDLE: begin
          if (rx_dv) rx_state_q <= mc1_q[`EFH_MC1_RXEN] ? efh_pkg::EFH_RX_PRE
                                                       : efh_pkg::EFH_RX_SKIP; // R22
        end
        efh_pkg::EFH_RX_PRE: begin
          if (!rx_dv) rx_state_q <= efh_pkg::EFH_RX_IDLE;
          else if (rx_byte == `EFH_SFD_BYTE) begin // R1
            rx_state_q <= efh_pkg::EFH_RX_DATA;
            rx_cnt_q   <= 16'h0000;
            rx_crc_q   <= `EFH_CRC_INIT;
            rx_ovf_q   <= 1'b0;
            rx_frame_q <= rx_pos_q;
          end
        end
        efh_pkg::EFH_RX_DATA: begin
          if (rx_dv) begin
            rx_crc_q <= crc_byte(rx_crc_q, rx_byte);
            if (rx_cnt_q != 16'hffff) rx_cnt_q <= rx_cnt_q + 16'h0001;
            if (rx_cnt_q < 16'h0006) dest_q <= {dest_q[39:0], rx_byte};
            if (rx_nxt == rdptr_q) rx_ovf_q <= 1'b1;
            if (!rx_ovf_q) rx_pos_q <= rx_nxt;
          end else begin
            rx_state_q <= efh_pkg::EFH_RX_IDLE;
            if (accept) begin
              rx_wrptr_vis_q <= rx_pos_q; // R17
              rx_last_len_q  <= rx_cnt_q;
              rx_last_stat_q <= {is_mc, is_bc, crc_ok, 1'b1};
            end else begin
              rx_pos_q <= rx_frame_q; // R11
            end
          end
        end
        efh_pkg::EFH_RX_SKIP: begin
          if (!rx_dv) rx_state_q <= efh_pkg::EFH_RX_IDLE;
        end
        default: rx_state_q <= efh_pkg::EFH_RX_IDLE;
      endcase
      if (rx_ptr_wr) rx_pos_q <= new_start; // R16
    end
  end

  // ----------------------------------------------------------------------
  // packet buffer write port: receive, then status vector, then host
  // ----------------------------------------------------------------------
  wire        mem_we = rx_wr || tsv_wr || wr_bufdat;
  wire [12:0] mem_wa = rx_wr ? rx_pos_q : (tsv_wr ? tsv_addr : bufptr_q);
  wire [7:0]  mem_wd = rx_wr ? rx_byte : (tsv_wr ? tsv_byte : reg_wdata[7:0]);
  assign reg_rdata = rdata_q;
  assign tx_byte   = tx_byte_q;
  assign tx_en     = tx_en_q;

  always_ff @(posedge clk_sys) begin
    if (mem_we) mem[mem_wa] <= mem_wd;
  end

endmodule : efh_frame_handler

// >>> sim/efh_asserts.sv
// efh_asserts.sv - port checks of the frame handler
// assumes bind onto efh_frame_handler, single clock domain
`timescale 1ns/1ns
module efh_asserts (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        clock_ready_in,
  input wire logic [7:0]  tx_byte,
  input wire logic        tx_en,
  input wire logic [7:0]  rx_byte,
  input wire logic        rx_dv
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ------
  // frame length and config shadow
  // ------
  logic [11:0] len_q;
  logic        pad_q;
  logic        huge_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      len_q  <= 12'h000;
      pad_q  <= 1'b0;
      huge_q <= 1'b0;
    end else begin
      len_q <= tx_en ? len_q + 12'h001 : 12'h000;
      if (reg_wr && reg_addr == 8'h04) begin
        pad_q  <= reg_wdata[1];
        huge_q <= reg_wdata[0];
      end
    end
  end
  sequence s_preamble;
    (tx_byte == 8'h55) [*7];
  endsequence
  sequence s_delim;
    tx_en && tx_byte == 8'hd5;
  endsequence
  a_pre_order: assert property ($rose(tx_en) |-> s_preamble ##1 s_delim)
    else $error("preamble or delimiter wrong");
  a_start_delay: assert property ($rose(tx_en) |->
    $past(reg_wr, 2) && ($past(reg_addr, 2) == 8'h30) && $past(reg_wdata[0], 2))
    else $error("frame start without command");
  a_tsv_gap: assert property ($fell(tx_en) |-> !tx_en [*8])
    else $error("no room for status vector");
  a_pad_min: assert property ($fell(tx_en) && pad_q |-> len_q >= 12'h048)
    else $error("padded frame too short");
  a_huge_cap: assert property (!huge_q |-> len_q <= 12'h5f6)
    else $error("frame too long");
  a_clk_status: assert property (reg_rd && reg_addr == 8'h34 |=>
    reg_rdata[0] == $past(clock_ready_in))
    else $error("clock ready bit wrong");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h40 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
endmodule : efh_asserts

bind efh_frame_handler efh_asserts i_efh_asserts (.clk_sys(clk_sys), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .clock_ready_in(clock_ready_in), .tx_byte(tx_byte),
  .tx_en(tx_en), .rx_byte(rx_byte), .rx_dv(rx_dv));

// >>> sim/efh_link_peer.sv
// efh_link_peer.sv - far end of the byte link: sends frames, records sent bytes
// assumes one byte a rising clk_sys edge
`timescale 1ns/1ns
module efh_link_peer (
  input  wire logic       clk_sys,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_en,
  output logic      [7:0] rx_byte,
  output logic            rx_dv
);
  logic [7:0] fb [0:1535];
  logic [7:0] cap [$];
  initial begin
    rx_byte = 8'h00;
    rx_dv   = 1'b0;
  end
  always @(posedge clk_sys) begin
    if (tx_en) begin
      cap.push_back(tx_byte);
    end
  end
  task send(input int n);
    for (int i = -8; i < n; i++) begin
      @(posedge clk_sys);
      rx_dv   <= 1'b1;
      rx_byte <= (i < -1) ? 8'h55 : (i == -1) ? 8'hd5 : fb[i];
    end
    @(posedge clk_sys);
    rx_dv   <= 1'b0;
    rx_byte <= ~rx_byte;
  endtask : send
endmodule : efh_link_peer

// >>> sim/tb.sv
// tb.sv - self-checking bench of the frame handler
// assumes efh_link_peer on the link, checker attached by bind
`timescale 1ns/1ns
module tb;
  logic        clk_sys;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        clock_ready_in;
  logic [7:0]  tx_byte;
  logic        tx_en;
  logic [7:0]  rx_byte;
  logic        rx_dv;
  logic [31:0] rd_q;
  logic [12:0] exp_wp;
  logic [7:0]  fr [0:1535];
  int          bad_count;
  int          tests_run;

  efh_frame_handler i_efh_frame_handler (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .clock_ready_in(clock_ready_in), .tx_byte(tx_byte),
    .tx_en(tx_en), .rx_byte(rx_byte), .rx_dv(rx_dv));
  efh_link_peer i_efh_link_peer (.clk_sys(clk_sys), .tx_byte(tx_byte), .tx_en(tx_en),
    .rx_byte(rx_byte), .rx_dv(rx_dv));

  always #10 clk_sys = ~clk_sys;
  // ------
  // bus and compare helpers
  // ------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask : rd
  function automatic logic [31:0] crc(input int n);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < n; i++) begin
      c = c ^ {24'h000000, fr[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    end
    return ~c;
  endfunction : crc
  task mk(input logic [7:0] d0, input int n, input logic good);
    logic [31:0] c;
    for (int i = 0; i < n - 4; i++) fr[i] = (i < 6) ? d0 : i[7:0];
    c = crc(n - 4) ^ {31'h0, !good};
    for (int i = 0; i < 4; i++) fr[n - 4 + i] = c[8*i +: 8];
    for (int i = 0; i < n; i++) i_efh_link_peer.fb[i] = fr[i];
  endtask : mk
  task rx_case(input logic [7:0] d0, input int n, input logic good, input logic acc);
    mk(d0, n, good);
    i_efh_link_peer.send(n);
    repeat (3) @(posedge clk_sys);
    if (acc) exp_wp = exp_wp + n[12:0];
    rd(8'h14);
    chk({19'h0, rd_q[12:0]}, {19'h0, exp_wp});
  endtask : rx_case
  // ------
  // scenarios
  // ------
  task t_reset;
    rd(8'h34);
    for (int m = 0; m < 50 && rd_q[0] !== 1'b1; m++) rd(8'h34);
    chk({31'h0, rd_q[0]}, 32'h1);
    rd(8'h08);
    chk(rd_q, 32'h85);
    rd(8'h10);
    chk(rd_q, 32'h1fff);
    rd(8'h44);
    chk(rd_q, 32'h0);
  endtask : t_reset
  task t_tx(input logic [31:0] mc3, input int n);
    wr(8'h04, mc3);
    wr(8'h20, 32'h0100);
    for (int i = 0; i < 60; i++) fr[i] = (i < 12) ? 8'h10 + i[7:0] : (i < 14) ? 8'h08 : 8'h00;
    for (int i = 0; i < 14; i++) wr(8'h24, {24'h0, fr[i]});
    wr(8'h28, 32'h0100);
    wr(8'h2c, 32'h010d);
    i_efh_link_peer.cap.delete();
    wr(8'h30, 32'h1);
    rd(8'h34);
    for (int m = 0; m < 200 && rd_q[1] !== 1'b0; m++) rd(8'h34);
    chk(32'(i_efh_link_peer.cap.size()), 32'(8 + n));
    if (mc3[1]) begin
      chk({24'h0, i_efh_link_peer.cap[67]}, 32'h0);
      chk({i_efh_link_peer.cap[71], i_efh_link_peer.cap[70], i_efh_link_peer.cap[69],
           i_efh_link_peer.cap[68]}, crc(60));
    end
    wr(8'h20, 32'h010e);
    rd(8'h24);
    chk(rd_q, 32'(n));
  endtask : t_tx
  task t_rx;
    logic [31:0] w0;
    rd(8'h14);
    w0 = rd_q;
    wr(8'h0c, 32'h1000);
    wr(8'h10, 32'h1fff);
    wr(8'h18, 32'h00);
    wr(8'h1c, 32'h10);
    rd(8'h14);
    chk(rd_q, w0);
    exp_wp = w0[12:0];
    rx_case(8'hff, 64, 1'b1, 1'b0);
    exp_wp = 13'h1000;
    wr(8'h00, 32'h1);
    rx_case(8'hff, 64, 1'b1, 1'b1);
    rd(8'h34);
    chk({28'h0, rd_q[5:2]}, 32'hf);
    wr(8'h20, 32'h1000);
    rd(8'h24);
    chk(rd_q, {24'h0, fr[0]});
    wr(8'h20, 32'h103f);
    rd(8'h24);
    chk(rd_q, {24'h0, fr[63]});
    rx_case(8'hff, 17, 1'b1, 1'b0);
    rx_case(8'hff, 18, 1'b1, 1'b1);
    rx_case(8'h01, 64, 1'b1, 1'b0);
    wr(8'h08, 32'h87);
    rx_case(8'h01, 64, 1'b1, 1'b1);
    rx_case(8'hff, 64, 1'b0, 1'b0);
    wr(8'h08, 32'h07);
    rx_case(8'hff, 64, 1'b0, 1'b1);
    rd(8'h34);
    chk({28'h0, rd_q[5:2]}, 32'hd);
    rd(8'h40);
    chk(rd_q, 32'h40);
    wr(8'h3c, 32'h0202);
    wr(8'h38, 32'h02020202);
    rx_case(8'h04, 64, 1'b1, 1'b0);
    rx_case(8'h02, 64, 1'b1, 1'b1);
    rd(8'h34);
    chk({28'h0, rd_q[5:2]}, 32'h3);
    rx_case(8'hff, 1519, 1'b1, 1'b0);
    wr(8'h04, 32'h1);
    rx_case(8'hff, 1519, 1'b1, 1'b1);
  endtask : t_rx
  task final_report;
    $display("checks %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report

  initial begin
    clk_sys        = 1'b0;
    rst_n          = 1'b0;
    reg_addr       = 8'h00;
    reg_wdata      = 32'h0;
    reg_wr         = 1'b0;
    reg_rd         = 1'b0;
    clock_ready_in = 1'b0;
    bad_count      = 0;
    tests_run      = 0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset;
    t_tx(32'h2, 64);
    t_tx(32'h0, 14);
    t_rx;
    final_report;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    clock_ready_in <= 1'b1;
  end
  initial begin
    #1_000_000;
    bad_count++;
    final_report;
  end
endmodule : tb
